// ==== rtl/clg_defines.svh ====
// Register map, field positions, reset values and timing figures of the logic gate
`ifndef CLG_DEFINES_SVH
`define CLG_DEFINES_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CLG_ADR_CTRL 8'h00
`define CLG_ADR_TIME 8'h04
`define CLG_ADR_SRC 8'h08
`define CLG_ADR_IDX 8'h0C
`define CLG_ADR_INIT 8'h10
`define CLG_ADR_TRUE 8'h14
`define CLG_ADR_FALSE 8'h18
`define CLG_ADR_STAT 8'h1C
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CLG_F_TYPE 2:0
`define CLG_F_NUSED 6:3
`define CLG_F_NNOT 9:7
`define CLG_F_ONCHG 10
`define CLG_F_DLYEN 11
`define CLG_F_CYCEN 12
`define CLG_F_LOCKEN 13
`define CLG_F_LOCKRET 15:14
`define CLG_F_DLYUNIT 17:16
`define CLG_F_CYCUNIT 19:18
`define CLG_F_DLYVAL 7:0
`define CLG_F_CYCVAL 15:8
`define CLG_F_INT 7:0
`define CLG_F_INV 15:8
`define CLG_F_BLK 23:16
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CLG_RST_CTRL 32'h0005_0090
`define CLG_RST_TIME 32'h0000_0101
`define CLG_RST_ZERO 32'h0000_0000
`define CLG_RST_TRUE 32'h0000_0001
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLG_CLK_MHZ 250
`define CLG_CLK_HZ (`CLG_CLK_MHZ * 1000000)
`define CLG_RD_WAIT_MS 1000
`define CLG_SEC_PER_SEC 17'h0_0001
`define CLG_SEC_PER_MIN 17'h0_003C
`define CLG_SEC_PER_HOUR 17'h0_0E10
`define CLG_SEC_PER_DAY 17'h1_5180
`define CLG_LOCK_SLOT 4'h8
`endif

// ==== rtl/clg_pkg.sv ====
// Types shared by the logic gate modules
package clg_pkg;
  typedef enum logic [2:0] {
    CLG_AND = 3'b000, CLG_OR = 3'b001, CLG_XOR = 3'b010, CLG_NAND = 3'b011,
    CLG_NOR = 3'b100, CLG_XNOR = 3'b101, CLG_ONEHOT = 3'b110, CLG_NOT = 3'b111
  } clg_gate_type;
  typedef enum logic [1:0] {
    CLG_INIT_ZERO = 2'b00, CLG_INIT_ONE = 2'b01, CLG_INIT_KEEP = 2'b10, CLG_INIT_READ = 2'b11
  } clg_init_type;
  typedef enum logic [1:0] {
    CLG_LK_UNLOCK = 2'b00, CLG_LK_LOCK = 2'b01, CLG_LK_READ = 2'b10, CLG_LK_KEEP = 2'b11
  } clg_lock_type;
  typedef enum logic [1:0] {
    CLG_U_SEC = 2'b00, CLG_U_MIN = 2'b01, CLG_U_HOUR = 2'b10, CLG_U_DAY = 2'b11
  } clg_unit_type;
  typedef enum logic [1:0] {
    CLG_SQ_IDLE = 2'b00, CLG_SQ_ISSUE = 2'b01, CLG_SQ_WAIT = 2'b10
  } clg_seq_type;
endpackage

// ==== rtl/clg_timer.sv ====
// Retriggerable timer counting a value in seconds, minutes, hours or days
`timescale 1ns/10ps
`default_nettype none
`include "clg_defines.svh"
module clg_timer
  import clg_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = `CLG_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [7:0] value_i,
  input wire clg_unit_type unit_i,
  output logic done_o,
  output logic busy_o
);
  logic [31:0] pre;
  logic [24:0] secs_left;

  // Seconds in one unit
  function automatic logic [16:0] unit_secs(input clg_unit_type u);
    case (u)
      CLG_U_SEC: unit_secs = `CLG_SEC_PER_SEC;
      CLG_U_MIN: unit_secs = `CLG_SEC_PER_MIN;
      CLG_U_HOUR: unit_secs = `CLG_SEC_PER_HOUR;
      default: unit_secs = `CLG_SEC_PER_DAY;
    endcase
  endfunction

  // Prescaler to seconds, then seconds countdown; a start restarts it
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || stop_i) begin
      busy_o <= 1'b0;
      pre <= 32'h0000_0000;
      secs_left <= 25'h000_0000;
    end else if (start_i) begin
      busy_o <= 1'b1;
      pre <= 32'h0000_0000;
      secs_left <= 25'(value_i * unit_secs(unit_i));
    end else if (busy_o) begin
      if (pre == 32'(CYC_PER_SEC - 1)) begin
        pre <= 32'h0000_0000;
        if (secs_left <= 25'h000_0001) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          secs_left <= secs_left - 25'h000_0001;
        end
      end else begin
        pre <= pre + 32'h0000_0001;
      end
    end
  end
endmodule // clg_timer
`default_nettype wire

// ==== rtl/clg_gate.sv ====
// Configurable eight-input logic gate with Wishbone registers and bus-object interface
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "clg_defines.svh"
module clg_gate
  import clg_pkg::*;
#(
  parameter int unsigned NUM_INT = 16,
  parameter int unsigned CYC_PER_SEC = `CLG_CLK_HZ,
  parameter int unsigned RD_WAIT_CYC = (`CLG_CLK_HZ / 1000) * `CLG_RD_WAIT_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Internal input signals
  input wire logic [NUM_INT-1:0] int_in_i,
  // Input object telegrams and read answers
  input wire logic obj_wr_i,
  input wire logic [2:0] obj_idx_i,
  input wire logic obj_val_i,
  input wire logic rd_resp_i,
  input wire logic [3:0] rd_resp_idx_i,
  input wire logic rd_resp_val_i,
  // Lock object and mains recovery
  input wire logic lock_wr_i,
  input wire logic lock_val_i,
  input wire logic recovery_i,
  // Read requests and output telegrams
  output logic rd_req_o,
  output logic [3:0] rd_req_idx_o,
  output logic tx_o,
  output logic [31:0] tx_data_o,
  output logic [3:0] not_tx_o,
  output logic [3:0] not_val_o
);
  localparam int IW = $clog2(NUM_INT);
  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [31:0] ctrl, times, src, idx, init, val_true, val_false;
  logic [7:0] obj_val, blk_pend, raw, eff, mask, upd_vec, upd_d;
  logic [NUM_INT-1:0] int_prev;
  logic [3:0] not_mask;
  logic [31:0] wait_cnt;
  logic [3:0] seq_idx;
  logic locked, result, upd_any, send_req, gate_now, lock_eff, tx_ok, seq_done;
  logic dly_done, dly_busy, cyc_done, cyc_busy, send_now;
  clg_seq_type seq;
  clg_gate_type gtype;

  assign gtype = clg_gate_type'(ctrl[`CLG_F_TYPE]);
  assign lock_eff = ctrl[`CLG_F_LOCKEN] & locked;
  assign tx_ok = ~lock_eff & ~(|blk_pend);

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // Start-value selection of one object input
  function automatic clg_init_type init_sel(input logic [31:0] r, input int i);
    init_sel = clg_init_type'(r[i*2 +: 2]);
  endfunction

  // ----------------------------------------------------------------------
  // Wishbone slave: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CLG_RST_CTRL;
      times <= `CLG_RST_TIME;
      src <= `CLG_RST_ZERO;
      idx <= `CLG_RST_ZERO;
      init <= `CLG_RST_ZERO;
      val_true <= `CLG_RST_TRUE;
      val_false <= `CLG_RST_ZERO;
    end else if (cyc_i && stb_i && we_i && !ack_o) begin
      if (adr_i == `CLG_ADR_CTRL) begin
        ctrl <= merge(ctrl, dat_i, sel_i);
      end else if (adr_i == `CLG_ADR_TIME) begin
        times <= merge(times, dat_i, sel_i);
      end else if (adr_i == `CLG_ADR_SRC) begin
        src <= merge(src, dat_i, sel_i);
      end else if (adr_i == `CLG_ADR_IDX) begin
        idx <= merge(idx, dat_i, sel_i);
      end else if (adr_i == `CLG_ADR_INIT) begin
        init <= merge(init, dat_i, sel_i);
      end else if (adr_i == `CLG_ADR_TRUE) begin
        val_true <= merge(val_true, dat_i, sel_i);
      end else if (adr_i == `CLG_ADR_FALSE) begin
        val_false <= merge(val_false, dat_i, sel_i);
      end
    end
  end

  // Register reads; status shows input values, result, lock and pending blocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_o) begin
      if (adr_i == `CLG_ADR_CTRL) begin
        dat_o <= ctrl;
      end else if (adr_i == `CLG_ADR_TIME) begin
        dat_o <= times;
      end else if (adr_i == `CLG_ADR_SRC) begin
        dat_o <= src;
      end else if (adr_i == `CLG_ADR_IDX) begin
        dat_o <= idx;
      end else if (adr_i == `CLG_ADR_INIT) begin
        dat_o <= init;
      end else if (adr_i == `CLG_ADR_TRUE) begin
        dat_o <= val_true;
      end else if (adr_i == `CLG_ADR_FALSE) begin
        dat_o <= val_false;
      end else if (adr_i == `CLG_ADR_STAT) begin
        dat_o <= {9'h000, not_val_o, blk_pend, dly_busy, lock_eff, result, raw};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input selection, polarity and change detection
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < 8; i++) begin : g_in
      logic [IW-1:0] sel_idx;
      assign sel_idx = idx[i*4 +: IW];
      assign raw[i] = src[i] ? int_in_i[sel_idx] : obj_val[i];
      assign eff[i] = raw[i] ^ src[8 + i];
      assign mask[i] = 4'(i) < ctrl[`CLG_F_NUSED];
      assign upd_vec[i] = src[i] ? (int_in_i[sel_idx] != int_prev[sel_idx])
                                 : ((obj_wr_i && obj_idx_i == 3'(i))
                                    || (rd_resp_i && rd_resp_idx_i == 4'(i)));
    end
    for (genvar j = 0; j < 4; j++) begin : g_not
      assign not_mask[j] = 3'(j) < ctrl[`CLG_F_NNOT];
    end
  endgenerate

  // Previous internal inputs for change detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_prev <= '0;
    end else begin
      int_prev <= int_in_i;
    end
  end

  // ----------------------------------------------------------------------
  // Gate evaluation over used inputs
  // ----------------------------------------------------------------------
  always_comb begin
    logic [3:0] ones;
    ones = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones = ones + 4'(eff[i] & mask[i]);
    end
    case (gtype)
      CLG_AND: gate_now = &(eff | ~mask);
      CLG_OR: gate_now = |(eff & mask);
      CLG_XOR: gate_now = ones[0];
      CLG_NAND: gate_now = ~&(eff | ~mask);
      CLG_NOR: gate_now = ~|(eff & mask);
      CLG_XNOR: gate_now = ~ones[0];
      CLG_ONEHOT: gate_now = (ones == 4'h1);
      default: gate_now = 1'b0;
    endcase
  end

  assign upd_any = |(upd_d & (gtype == CLG_NOT ? {4'h0, not_mask} : mask)) | seq_done;

  // Object input values: telegrams, read answers and start values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      obj_val <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (obj_wr_i && obj_idx_i == 3'(i)) begin
          obj_val[i] <= obj_val_i;
        end else if (rd_resp_i && rd_resp_idx_i == 4'(i)) begin
          obj_val[i] <= rd_resp_val_i;
        end else if (seq == CLG_SQ_WAIT && seq_idx == 4'(i)
                     && wait_cnt == 32'(RD_WAIT_CYC - 1)) begin
          obj_val[i] <= 1'b0;
        end else if (recovery_i && gtype != CLG_NOT) begin
          if (init_sel(init, i) == CLG_INIT_ZERO) begin
            obj_val[i] <= 1'b0;
          end else if (init_sel(init, i) == CLG_INIT_ONE) begin
            obj_val[i] <= 1'b1;
          end
        end
      end
    end
  end

  // Pending blocks: armed by recovery, cleared by a telegram on that input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_pend <= 8'h00;
    end else if (recovery_i && gtype != CLG_NOT) begin
      blk_pend <= src[`CLG_F_BLK] & ~src[`CLG_F_INT] & mask;
    end else begin
      blk_pend <= blk_pend & ~(upd_vec & ~src[`CLG_F_INT]);
    end
  end

  // ----------------------------------------------------------------------
  // Start-up read sequence for inputs and lock
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    rd_req_o <= 1'b0;
    seq_done <= 1'b0;
    if (rst_i) begin
      seq <= CLG_SQ_IDLE;
      seq_idx <= 4'h0;
      wait_cnt <= 32'h0000_0000;
      rd_req_idx_o <= 4'h0;
    end else if (recovery_i) begin
      seq <= CLG_SQ_ISSUE;
      seq_idx <= 4'h0;
    end else begin
      case (seq)
        CLG_SQ_ISSUE: begin
          wait_cnt <= 32'h0000_0000;
          if (seq_idx == `CLG_LOCK_SLOT) begin
            if (ctrl[`CLG_F_LOCKEN]
                && clg_lock_type'(ctrl[`CLG_F_LOCKRET]) == CLG_LK_READ) begin
              rd_req_o <= 1'b1;
              rd_req_idx_o <= seq_idx;
              seq <= CLG_SQ_WAIT;
            end else begin
              seq <= CLG_SQ_IDLE;
              seq_done <= 1'b1;
            end
          end else if (gtype != CLG_NOT && !src[seq_idx[2:0]] && mask[seq_idx[2:0]]
                       && init_sel(init, int'(seq_idx)) == CLG_INIT_READ) begin
            rd_req_o <= 1'b1;
            rd_req_idx_o <= seq_idx;
            seq <= CLG_SQ_WAIT;
          end else begin
            seq_idx <= seq_idx + 4'h1;
          end
        end
        CLG_SQ_WAIT: begin
          wait_cnt <= wait_cnt + 32'h0000_0001;
          if ((rd_resp_i && rd_resp_idx_i == seq_idx)
              || wait_cnt == 32'(RD_WAIT_CYC - 1)) begin
            if (seq_idx == `CLG_LOCK_SLOT) begin
              seq <= CLG_SQ_IDLE;
              seq_done <= 1'b1;
            end else begin
              seq <= CLG_SQ_ISSUE;
              seq_idx <= seq_idx + 4'h1;
            end
          end
        end
        default: seq <= CLG_SQ_IDLE;
      endcase
    end
  end

  // Lock state: written by the lock object, set up at recovery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked <= 1'b0;
    end else if (lock_wr_i) begin
      locked <= lock_val_i;
    end else if (rd_resp_i && rd_resp_idx_i == `CLG_LOCK_SLOT) begin
      locked <= rd_resp_val_i;
    end else if (recovery_i) begin
      case (clg_lock_type'(ctrl[`CLG_F_LOCKRET]))
        CLG_LK_UNLOCK: locked <= 1'b0;
        CLG_LK_LOCK: locked <= 1'b1;
        CLG_LK_READ: locked <= 1'b0;
        default: locked <= locked;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Evaluation one tick after an update and send decision
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_d <= 8'h00;
      result <= 1'b0;
      send_req <= 1'b0;
    end else begin
      upd_d <= upd_vec;
      send_req <= 1'b0;
      if (upd_any && gtype != CLG_NOT) begin
        result <= gate_now;
        send_req <= ctrl[`CLG_F_ONCHG] ? (gate_now != result) : 1'b1;
      end
    end
  end

  // Independent inverters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      not_val_o <= 4'h0;
      not_tx_o <= 4'h0;
    end else if (upd_any && gtype == CLG_NOT) begin
      not_val_o <= ~raw[3:0] & not_mask;
      not_tx_o <= upd_d[3:0] & not_mask & {4{~lock_eff}};
    end else begin
      not_tx_o <= 4'h0;
    end
  end

  // Delay and cycle timers
  clg_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_dly (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(send_req && ctrl[`CLG_F_DLYEN]),
    .stop_i(!ctrl[`CLG_F_DLYEN]),
    .value_i(times[`CLG_F_DLYVAL]),
    .unit_i(clg_unit_type'(ctrl[`CLG_F_DLYUNIT])),
    .done_o(dly_done),
    .busy_o(dly_busy)
  );
  clg_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_cyc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tx_o || !cyc_busy),
    .stop_i(!ctrl[`CLG_F_CYCEN] || gtype == CLG_NOT),
    .value_i(times[`CLG_F_CYCVAL]),
    .unit_i(clg_unit_type'(ctrl[`CLG_F_CYCUNIT])),
    .done_o(cyc_done),
    .busy_o(cyc_busy)
  );

  assign send_now = ((send_req && !ctrl[`CLG_F_DLYEN]) || dly_done || cyc_done) && tx_ok;

  // Output telegram with the true or false value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b0;
      tx_data_o <= 32'h0000_0000;
    end else begin
      tx_o <= send_now && gtype != CLG_NOT;
      if (send_now) begin
        tx_data_o <= result ? val_true : val_false;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_eval(clg_gate_type t);
    upd_any && gtype == t;
  endsequence

  a_and_eval: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval(CLG_AND) |=> result == &($past(eff) | ~$past(mask)))
    else $error("AND result wrong");
  a_xor_eval: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval(CLG_XOR) |=> result == ^($past(eff) & $past(mask)))
    else $error("XOR result wrong");
  a_nor_eval: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval(CLG_NOR) |=> result == (($past(eff) & $past(mask)) == 8'h00))
    else $error("NOR result wrong");
  a_onehot_eval: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval(CLG_ONEHOT) |=> result == $onehot($past(eff) & $past(mask)))
    else $error("one-hot result wrong");
  a_not_value: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval(CLG_NOT) |=> not_val_o == (~$past(raw[3:0]) & $past(not_mask)))
    else $error("inverter output wrong");
  a_block_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (|blk_pend) |=> !tx_o)
    else $error("output sent while blocked");
  a_change_only: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval(CLG_AND) ##0 ctrl[`CLG_F_ONCHG] ##0 (gate_now == result) |=> !send_req)
    else $error("send without output change");
  a_update_send: assert property (@(posedge clk_i) disable iff (rst_i)
    (upd_any && gtype != CLG_NOT && !ctrl[`CLG_F_ONCHG] && !ctrl[`CLG_F_DLYEN]
     && tx_ok && !recovery_i && !lock_wr_i) |=> send_req ##1 tx_o)
    else $error("update not sent");
  a_read_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq == CLG_SQ_WAIT && seq_idx < `CLG_LOCK_SLOT && wait_cnt == 32'(RD_WAIT_CYC - 1)
     && !rd_resp_i && !obj_wr_i && !recovery_i) |=> obj_val[$past(seq_idx[2:0])] == 1'b0)
    else $error("timed-out input not zero");
  a_lock_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_eff |=> !tx_o)
    else $error("output sent while locked");
endmodule // clg_gate
`default_nettype wire

// ==== tb/clg_bus_model.sv ====
// Bus responder that answers read requests of the logic gate after a delay
`timescale 1ns/10ps
`default_nettype none
module clg_bus_model #(parameter int DLY = 12) (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [3:0] req_idx_i,
  input wire logic answer_i,
  output logic resp_o = 1'b0,
  output logic [3:0] resp_idx_o = 4'h0,
  output logic resp_val_o = 1'b0
);
  int cnt = 0;
  logic [3:0] idx = 4'h0;
  // Answers the last request DLY cycles later; released lines keep toggling
  always @(posedge clk_i) begin
    resp_o <= 1'b0;
    resp_idx_o <= ~resp_idx_o;
    resp_val_o <= ~resp_val_o;
    cnt <= (cnt > 0) ? cnt - 1 : 0;
    if (req_i === 1'b1) begin
      idx <= req_idx_i;
      cnt <= DLY;
    end
    if (cnt == 1 && answer_i) begin
      resp_o <= 1'b1;
      resp_idx_o <= idx;
      resp_val_o <= 1'b1;
    end
  end
endmodule // clg_bus_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench of the configurable logic gate
`timescale 1ns/10ps
`default_nettype none
`include "clg_defines.svh"
module tb;
  import clg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, tx_data_o, last_tx, q;
  logic [15:0] int_in_i = 16'h0000;
  logic obj_wr_i = 1'b0, obj_val_i = 1'b0, recovery_i = 1'b0, ans = 1'b1;
  logic lock_wr_i = 1'b0, lock_val_i = 1'b0;
  logic [2:0] obj_idx_i = 3'h0;
  logic ack_o, rd_resp_i, rd_resp_val_i, rd_req_o, tx_o;
  logic [3:0] rd_resp_idx_i, rd_req_idx_o, not_tx_o, not_val_o;
  int failures = 0, n_checks = 0, n_tx = 0, n_req = 0, n_ntx = 0, base;

  clg_gate #(.CYC_PER_SEC(10), .RD_WAIT_CYC(20)) i_clg_gate (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .int_in_i(int_in_i), .obj_wr_i(obj_wr_i),
    .obj_idx_i(obj_idx_i), .obj_val_i(obj_val_i), .rd_resp_i(rd_resp_i),
    .rd_resp_idx_i(rd_resp_idx_i), .rd_resp_val_i(rd_resp_val_i), .lock_wr_i(lock_wr_i),
    .lock_val_i(lock_val_i), .recovery_i(recovery_i), .rd_req_o(rd_req_o),
    .rd_req_idx_o(rd_req_idx_o), .tx_o(tx_o), .tx_data_o(tx_data_o), .not_tx_o(not_tx_o),
    .not_val_o(not_val_o));
  clg_bus_model i_clg_bus_model (.clk_i(clk_i), .req_i(rd_req_o), .req_idx_i(rd_req_idx_o),
    .answer_i(ans), .resp_o(rd_resp_i), .resp_idx_o(rd_resp_idx_i),
    .resp_val_o(rd_resp_val_i));

  // Clock and hang guard
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    failures++;
    test_done();
  end

  // Counts output telegrams and read requests, keeps the last sent value
  always @(posedge clk_i) begin
    if (tx_o === 1'b1) begin
      n_tx <= n_tx + 1;
      last_tx <= tx_data_o;
    end
    if (rd_req_o === 1'b1) n_req <= n_req + 1;
    if ((|not_tx_o) === 1'b1) n_ntx <= n_ntx + 1;
  end

  task automatic test_done();
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 40) begin
      failures++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // One input telegram, then time for evaluation and sending
  task automatic obj(input logic [2:0] i, input logic v);
    @(posedge clk_i);
    obj_wr_i <= 1'b1;
    obj_idx_i <= i;
    obj_val_i <= v;
    @(posedge clk_i);
    obj_wr_i <= 1'b0;
    obj_val_i <= ~v;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic recover();
    @(posedge clk_i);
    recovery_i <= 1'b1;
    @(posedge clk_i);
    recovery_i <= 1'b0;
    repeat (120) @(posedge clk_i);
  endtask

  function automatic logic gate_exp(input logic [2:0] t, input logic [2:0] v);
    case (t)
      3'h0: return &v;
      3'h1: return |v;
      3'h2: return ^v;
      3'h3: return ~&v;
      3'h4: return ~|v;
      3'h5: return ~^v;
      default: return $countones(v) == 1;
    endcase
  endfunction

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`CLG_ADR_CTRL, `CLG_RST_CTRL);
    rd(`CLG_ADR_TRUE, `CLG_RST_TRUE);
    wr(8'h20, 32'h1234_5678);
    rd(8'h20, 32'h0000_0000);
    // Three inputs: input 0 inverted, input 1 from internal signal 5, input 3 unused
    wr(`CLG_ADR_SRC, 32'h0000_0102);
    wr(`CLG_ADR_IDX, 32'h0000_0050);
    obj(3'h3, 1'b1);
    for (int t = 0; t < 7; t++) begin
      wr(`CLG_ADR_CTRL, 32'h0000_0018 | 32'(t));
      for (int p = 0; p < 8; p++) begin
        int_in_i[5] <= p[1];
        obj(3'h0, p[0]);
        obj(3'h2, p[2]);
        wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
        chk({31'h0, q[8]}, {31'h0, gate_exp(3'(t), {p[2], p[1], ~p[0]})});
      end
    end
    // Send on update, then send on change, with distinct true and false values
    wr(`CLG_ADR_SRC, 32'h0000_0000);
    wr(`CLG_ADR_TRUE, 32'h0000_00A5);
    wr(`CLG_ADR_FALSE, 32'h0000_005A);
    wr(`CLG_ADR_CTRL, 32'h0000_0011);
    obj(3'h1, 1'b0);
    base = n_tx;
    repeat (3) obj(3'h0, 1'b1);
    chk(32'(n_tx - base), 32'h3);
    chk(last_tx, 32'h0000_00A5);
    wr(`CLG_ADR_CTRL, 32'h0000_0411);
    base = n_tx;
    obj(3'h0, 1'b1);
    obj(3'h0, 1'b0);
    obj(3'h0, 1'b0);
    chk(32'(n_tx - base), 32'h1);
    chk(last_tx, 32'h0000_005A);
    // Four inverters
    wr(`CLG_ADR_CTRL, 32'h0000_0207);
    base = n_ntx;
    obj(3'h1, 1'b1);
    obj(3'h2, 1'b0);
    obj(3'h3, 1'b1);
    chk(32'(n_ntx - base), 32'h3);
    chk({28'h0, not_val_o}, 32'h0000_0005);
    // Recovery with start values read from the bus, answered and unanswered
    wr(`CLG_ADR_CTRL, 32'h0000_0011);
    wr(`CLG_ADR_INIT, 32'h0000_000F);
    base = n_req;
    recover();
    chk(32'(n_req - base), 32'h2);
    wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
    chk({30'h0, q[1:0]}, 32'h3);
    ans <= 1'b0;
    recover();
    wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
    chk({30'h0, q[1:0]}, 32'h0);
    // Lock read back after recovery, answered and unanswered, then lock object
    wr(`CLG_ADR_INIT, 32'h0000_0000);
    wr(`CLG_ADR_CTRL, 32'h0000_A011);
    ans <= 1'b1;
    base = n_req;
    recover();
    chk(32'(n_req - base), 32'h1);
    wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
    chk({31'h0, q[9]}, 32'h1);
    base = n_tx;
    obj(3'h0, 1'b1);
    chk(32'(n_tx - base), 32'h0);
    ans <= 1'b0;
    recover();
    wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
    chk({31'h0, q[9]}, 32'h0);
    lock_val_i <= 1'b1;
    lock_wr_i <= 1'b1;
    @(posedge clk_i);
    lock_wr_i <= 1'b0;
    wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
    chk({31'h0, q[9]}, 32'h1);
    // Start values of one, then output blocked until input 0 gets a telegram
    wr(`CLG_ADR_CTRL, 32'h0000_0011);
    wr(`CLG_ADR_SRC, 32'h0001_0000);
    wr(`CLG_ADR_INIT, 32'h0000_0005);
    recover();
    wb(1'b0, `CLG_ADR_STAT, 32'h0, q);
    chk({30'h0, q[1:0]}, 32'h3);
    base = n_tx;
    obj(3'h1, 1'b1);
    chk(32'(n_tx - base), 32'h0);
    obj(3'h0, 1'b0);
    chk(32'(n_tx - base), 32'h1);
    chk(last_tx, 32'h0000_00A5);
    // Send delayed by one second of ten cycles
    wr(`CLG_ADR_CTRL, 32'h0000_0811);
    base = n_tx;
    obj(3'h0, 1'b1);
    repeat (8) @(posedge clk_i);
    chk(32'(n_tx - base), 32'h0);
    repeat (7) @(posedge clk_i);
    chk(32'(n_tx - base), 32'h1);
    // Cyclic resend every second; restart at each send gives twelve cycles
    wr(`CLG_ADR_CTRL, 32'h0000_1011);
    repeat (30) @(posedge clk_i);
    base = n_tx;
    repeat (60) @(posedge clk_i);
    chk(32'(n_tx - base), 32'h5);
    test_done();
  end
endmodule // tb
`default_nettype wire
